// ### src/msseq_pkg.sv
/*
  Shared constants and types of the multi-speed sequencer: register
  offsets, reset values, field limits, source codes and timing counts.
  Assumes a single 40 MHz clock and a 16-bit parameter word.
*/
package msseq_pkg;

  // ==========================================================
  // Clock and timing.
  localparam int CLK_HZ = 40_000_000;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (CLK_HZ / 1_000_000) * US_NS / 1000;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;

  // ==========================================================
  // Widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SEG_N = 16;

  // ==========================================================
  // Register offsets.
  localparam logic [7:0] OFS_METHOD = 8'h00;
  localparam logic [7:0] OFS_TOTAL = 8'h01;
  localparam logic [7:0] OFS_UNIT = 8'h02;
  localparam logic [7:0] OFS_PAIR_BASE = 8'h03;
  localparam logic [7:0] OFS_PAIR_LAST = 8'h0a;
  localparam logic [7:0] OFS_GEN_ACCEL = 8'h0b;
  localparam logic [7:0] OFS_GEN_DECEL = 8'h0c;
  localparam logic [7:0] OFS_SRC_SEL = 8'h0d;
  localparam logic [7:0] OFS_STATUS = 8'h0e;
  localparam logic [7:0] OFS_SPEED_NOW = 8'h0f;
  localparam logic [1:0] SEG_REGION = 2'h1;
  localparam logic [1:0] FLD_SPEED = 2'h0;
  localparam logic [1:0] FLD_DUR = 2'h1;
  localparam logic [1:0] FLD_RAMP = 2'h2;

  // ==========================================================
  // Reset values and limits.
  localparam logic [15:0] METHOD_RST = 16'h0000;
  localparam logic [15:0] TOTAL_RST = 16'h0010;
  localparam logic [15:0] UNIT_RST = 16'h0001;
  localparam logic [15:0] RAMP_TIME_RST = 16'h01f4;
  localparam logic [15:0] GEN_TIME_RST = 16'h01f4;
  localparam logic [15:0] SRC_SEL_RST = 16'h0000;
  localparam logic [15:0] SEG_SPEED_RST = 16'h0000;
  localparam logic [15:0] SEG_DUR_RST = 16'h000a;
  localparam logic [2:0] SEG_RAMP_RST = 3'h0;
  localparam logic [15:0] METHOD_MAX = 16'h0002;
  localparam logic [15:0] TOTAL_MIN = 16'h0001;
  localparam logic [15:0] TOTAL_MAX = 16'h0010;
  localparam logic [15:0] UNIT_MAX = 16'h0001;
  localparam logic [15:0] TIME_MAX = 16'h7fff;
  localparam logic [15:0] RAMP_SEL_MAX = 16'h0004;
  localparam logic [15:0] SPEED_BAD = 16'h8000;
  localparam logic [15:0] SRC_SEL_MAX = 16'h0007;

  // ==========================================================
  // Codes.
  localparam logic [1:0] METH_SINGLE = 2'h0;
  localparam logic [1:0] METH_CYCLE = 2'h1;
  localparam logic [1:0] METH_INPUT = 2'h2;
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_AUX = 3'h1;
  localparam logic [2:0] SRC_SWITCH = 3'h2;
  localparam logic [2:0] SRC_MULTI = 3'h5;

  // ==========================================================
  // Types.
  typedef struct packed {
    logic signed [15:0] speed;
    logic [15:0] dur;
    logic [2:0] ramp;
  } msseq_seg_t;

  typedef struct packed {
    logic running;
    logic stopped;
    logic [3:0] seg;
  } msseq_stat_t;

endpackage

// ### src/msseq_top.sv
/*
  Multi-speed sequencer of a servo speed mode, with its parameter file.
  Assumes synchronous inputs, one 40 MHz clock and a plain register port
  whose read data appear one cycle after the read strobe.
*/
`timescale 1ns/100ps
module msseq_top
  import msseq_pkg::*;
#(
  parameter int US_DIV = US_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic SERVO_EN,
  input wire logic MAIN_AUX_SWITCH,
  input wire logic [3:0] SEG_SELECT,
  input wire logic signed [15:0] MAIN_SPEED,
  input wire logic signed [15:0] AUX_SPEED,
  output logic signed [15:0] SPEED_CMD,
  output logic [3:0] ACTIVE_SEGMENT,
  output logic SEQ_RUNNING,
  output logic SEQ_STOPPED
);

  // ==========================================================
  // Elaboration check.
  // The microsecond divider counts in sixteen bits, so larger divides
  // would have their terminal count truncated to sixteen bits.
  if (US_DIV < 1 || US_DIV > 65535) begin : g_bad_div
    $error("US_DIV must lie between 1 and 65535");
  end

  // Stop is a parking state: a new pass needs enable to drop and return,
  // so a finished run cannot restart on its own.
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} msseq_state_t;

  // ==========================================================
  // Parameter storage.
  // Segments are plain flops; a memory would save area but would need a
  // read port each for the running segment, which the sequencer and the ramp share, and for the bus.
  logic [1:0] method_r;
  logic [4:0] total_r;
  logic unit_r;
  logic [15:0] pair_r [8];
  logic [15:0] gen_accel_r;
  logic [15:0] gen_decel_r;
  logic [2:0] src_sel_r;
  msseq_seg_t seg_r [SEG_N];

  // ==========================================================
  // Address decode.
  // Each segment takes four words from 0x40 upward; its fourth word
  // reads zero and ignores writes.
  wire in_seg = REG_ADDR[7:6] == SEG_REGION;
  wire [3:0] seg_a = REG_ADDR[5:2];
  wire [1:0] fld_a = REG_ADDR[1:0];
  wire in_pair = REG_ADDR >= OFS_PAIR_BASE && REG_ADDR <= OFS_PAIR_LAST;
  wire [2:0] pair_a = 3'(REG_ADDR - OFS_PAIR_BASE);
  wire time_ok = REG_WDATA <= TIME_MAX;
  wire wr_method = REG_WR && REG_ADDR == OFS_METHOD && !SERVO_EN
    && REG_WDATA <= METHOD_MAX;
  wire wr_total = REG_WR && REG_ADDR == OFS_TOTAL
    && REG_WDATA >= TOTAL_MIN && REG_WDATA <= TOTAL_MAX;
  wire wr_unit = REG_WR && REG_ADDR == OFS_UNIT && REG_WDATA <= UNIT_MAX;
  wire wr_pair = REG_WR && in_pair && time_ok;
  wire wr_gen_acc = REG_WR && REG_ADDR == OFS_GEN_ACCEL && time_ok;
  wire wr_gen_dec = REG_WR && REG_ADDR == OFS_GEN_DECEL && time_ok;
  wire wr_src = REG_WR && REG_ADDR == OFS_SRC_SEL
    && REG_WDATA <= SRC_SEL_MAX;
  wire wr_speed = REG_WR && in_seg && fld_a == FLD_SPEED
    && REG_WDATA != SPEED_BAD;
  wire wr_dur = REG_WR && in_seg && fld_a == FLD_DUR && time_ok;
  wire wr_ramp = REG_WR && in_seg && fld_a == FLD_RAMP
    && REG_WDATA <= RAMP_SEL_MAX;

  // Out-of-range values are dropped so a register never holds a code
  // the sequencer cannot act on.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      method_r <= METHOD_RST[1:0];
      total_r <= TOTAL_RST[4:0];
      unit_r <= UNIT_RST[0];
      gen_accel_r <= GEN_TIME_RST;
      gen_decel_r <= GEN_TIME_RST;
      src_sel_r <= SRC_SEL_RST[2:0];
    end else begin
      if (wr_method) begin
        method_r <= REG_WDATA[1:0];
      end
      if (wr_total) begin
        total_r <= REG_WDATA[4:0];
      end
      if (wr_unit) begin
        unit_r <= REG_WDATA[0];
      end
      if (wr_gen_acc) begin
        gen_accel_r <= REG_WDATA;
      end
      if (wr_gen_dec) begin
        gen_decel_r <= REG_WDATA;
      end
      if (wr_src) begin
        src_sel_r <= REG_WDATA[2:0];
      end
    end
  end

  for (genvar p = 0; p < 8; p++) begin : g_pair
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        pair_r[p] <= RAMP_TIME_RST;
      end else if (wr_pair && pair_a == 3'(p)) begin
        pair_r[p] <= REG_WDATA;
      end
    end
  end

  for (genvar s = 0; s < SEG_N; s++) begin : g_seg
    wire hit = seg_a == 4'(s);
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        seg_r[s].speed <= SEG_SPEED_RST;
        seg_r[s].dur <= SEG_DUR_RST;
        seg_r[s].ramp <= SEG_RAMP_RST;
      end else begin
        if (wr_speed && hit) begin
          seg_r[s].speed <= REG_WDATA;
        end
        if (wr_dur && hit) begin
          seg_r[s].dur <= REG_WDATA;
        end
        if (wr_ramp && hit) begin
          seg_r[s].ramp <= REG_WDATA[2:0];
        end
      end
    end
  end

  // ==========================================================
  // Time base.
  logic [15:0] us_cnt_r;
  logic [9:0] ms_cnt_r;
  logic [9:0] s_cnt_r;
  logic seg_start;
  wire us_tick = us_cnt_r == 16'(US_DIV - 1);
  wire ms_tick = us_tick && ms_cnt_r == 10'(US_PER_MS - 1);
  wire s_tick = ms_tick && s_cnt_r == 10'(MS_PER_S - 1);
  wire unit_tick = unit_r ? s_tick : ms_tick;

  // Unit dividers restart with each segment so a segment lasts its full
  // time rather than up to one unit less.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || seg_start) begin
      us_cnt_r <= 16'h0000;
      ms_cnt_r <= 10'h000;
      s_cnt_r <= 10'h000;
    end else begin
      us_cnt_r <= us_tick ? 16'h0000 : us_cnt_r + 16'h0001;
      if (us_tick) begin
        ms_cnt_r <= ms_tick ? 10'h000 : ms_cnt_r + 10'h001;
      end
      if (ms_tick) begin
        s_cnt_r <= s_tick ? 10'h000 : s_cnt_r + 10'h001;
      end
    end
  end

  // ==========================================================
  // Segment sequencer.
  // In input mode the segment timer is not consulted: the select bits
  // alone decide when the segment changes.
  msseq_state_t state_r;
  msseq_state_t state_nxt;
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;
  logic [15:0] seg_time_r;
  msseq_seg_t cur;
  assign cur = seg_r[idx_r];
  wire dur_done = seg_time_r >= cur.dur;
  // Greater-or-equal also ends a pass when the total is lowered below
  // the segment that is running.
  wire last_seg = {1'b0, idx_r} + 5'h01 >= total_r;
  wire sel_changed = SEG_SELECT != idx_r;

  // Dropping enable overrides every state and clears the ramp, so with the multi-speed
  // source selected the command falls back to zero two cycles after a disable.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    seg_start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (SERVO_EN) begin
          state_nxt = ST_RUN;
          seg_start = 1'b1;
          idx_nxt = method_r == METH_INPUT ? SEG_SELECT : 4'h0;
        end
      end
      ST_RUN: begin
        if (method_r == METH_INPUT) begin
          if (sel_changed) begin
            idx_nxt = SEG_SELECT;
            seg_start = 1'b1;
          end
        end else if (dur_done) begin
          seg_start = 1'b1;
          if (last_seg && method_r == METH_SINGLE) begin
            state_nxt = ST_STOP;
          end else if (last_seg) begin
            idx_nxt = 4'h0;
          end else begin
            idx_nxt = idx_r + 4'h1;
          end
        end
      end
      ST_STOP: begin
        state_nxt = ST_STOP;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!SERVO_EN) begin
      state_nxt = ST_IDLE;
      seg_start = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_r <= ST_IDLE;
      idx_r <= 4'h0;
      seg_time_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      if (seg_start) begin
        seg_time_r <= 16'h0000;
      end else if (unit_tick && !dur_done) begin
        seg_time_r <= seg_time_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Ramp generator.
  // One rpm step per ramp-time microseconds gives 1000 rpm per ramp time.
  // A zero ramp time jumps straight to the target; the step counter avoids
  // a divider at the cost of a fixed 1000 rpm reference.
  logic signed [15:0] ramp_r;
  logic [15:0] ramp_cnt_r;
  wire signed [15:0] target = state_r == ST_RUN ? cur.speed : 16'sh0000;
  wire rising = target > ramp_r;
  wire away = rising ? ramp_r >= 16'sh0000 : ramp_r <= 16'sh0000;
  wire [2:0] pair_sel = cur.ramp - 3'h1;
  wire [15:0] pair_acc = pair_r[{pair_sel[1:0], 1'b0}];
  wire [15:0] pair_dec = pair_r[{pair_sel[1:0], 1'b1}];
  wire [15:0] acc_time = cur.ramp == 3'h0 ? gen_accel_r : pair_acc;
  wire [15:0] dec_time = cur.ramp == 3'h0 ? gen_decel_r : pair_dec;
  wire [15:0] ramp_time = away ? acc_time : dec_time;
  wire ramp_step = us_tick && ramp_cnt_r + 16'h0001 >= ramp_time;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !SERVO_EN) begin
      ramp_r <= 16'sh0000;
      ramp_cnt_r <= 16'h0000;
    end else if (ramp_r == target) begin
      ramp_cnt_r <= 16'h0000;
    end else if (ramp_time == 16'h0000) begin
      ramp_r <= target;
    end else if (ramp_step) begin
      ramp_cnt_r <= 16'h0000;
      ramp_r <= rising ? ramp_r + 16'sh0001 : ramp_r - 16'sh0001;
    end else if (us_tick) begin
      ramp_cnt_r <= ramp_cnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // Speed command selection.
  // Source codes with no meaning here command zero rather than a stale
  // value, so a stray selection cannot spin the motor.
  logic signed [15:0] cmd_nxt;
  always_comb begin
    case (src_sel_r)
      SRC_MAIN: cmd_nxt = MAIN_SPEED;
      SRC_AUX: cmd_nxt = AUX_SPEED;
      SRC_SWITCH: cmd_nxt = MAIN_AUX_SWITCH ? AUX_SPEED : MAIN_SPEED;
      SRC_MULTI: cmd_nxt = ramp_r;
      default: cmd_nxt = 16'sh0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SPEED_CMD <= 16'sh0000;
      ACTIVE_SEGMENT <= 4'h0;
      SEQ_RUNNING <= 1'b0;
      SEQ_STOPPED <= 1'b0;
    end else begin
      SPEED_CMD <= cmd_nxt;
      ACTIVE_SEGMENT <= idx_r;
      SEQ_RUNNING <= state_r == ST_RUN;
      SEQ_STOPPED <= state_r == ST_STOP;
    end
  end

  // ==========================================================
  // Read port.
  // Read data are cleared outside the read cycle, so the bus reads zero
  // whenever nothing is being read.
  msseq_stat_t stat;
  assign stat = '{running: state_r == ST_RUN, stopped: state_r == ST_STOP,
                  seg: idx_r};
  msseq_seg_t rseg;
  assign rseg = seg_r[seg_a];
  logic [15:0] rd_nxt;
  always_comb begin
    rd_nxt = 16'h0000;
    if (in_seg) begin
      case (fld_a)
        FLD_SPEED: rd_nxt = rseg.speed;
        FLD_DUR: rd_nxt = rseg.dur;
        FLD_RAMP: rd_nxt = {13'h0000, rseg.ramp};
        default: rd_nxt = 16'h0000;
      endcase
    end else if (in_pair) begin
      rd_nxt = pair_r[pair_a];
    end else begin
      case (REG_ADDR)
        OFS_METHOD: rd_nxt = {14'h0000, method_r};
        OFS_TOTAL: rd_nxt = {11'h000, total_r};
        OFS_UNIT: rd_nxt = {15'h0000, unit_r};
        OFS_GEN_ACCEL: rd_nxt = gen_accel_r;
        OFS_GEN_DECEL: rd_nxt = gen_decel_r;
        OFS_SRC_SEL: rd_nxt = {13'h0000, src_sel_r};
        OFS_STATUS: rd_nxt = {10'h000, stat};
        OFS_SPEED_NOW: rd_nxt = SPEED_CMD;
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      REG_RDATA <= rd_nxt;
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule

// ### verif/msseq_assertions.sv
/*
  Port checker of the multi-speed sequencer, bound into msseq_top.
  Assumes one clock and a synchronous reset; the shadow copies drop
  out-of-range method and source writes as the sequencer does.
*/
`timescale 1ns/100ps
module msseq_assertions
  import msseq_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic SERVO_EN,
  input wire logic MAIN_AUX_SWITCH,
  input wire logic [3:0] SEG_SELECT,
  input wire logic signed [15:0] MAIN_SPEED,
  input wire logic signed [15:0] AUX_SPEED,
  input wire logic signed [15:0] SPEED_CMD,
  input wire logic [3:0] ACTIVE_SEGMENT,
  input wire logic SEQ_RUNNING,
  input wire logic SEQ_STOPPED
);
  // ==========================================================
  // Shadow copies.
  // Snooping the writes lets the checker know source and method.
  logic [2:0] src_r;
  logic [2:0] src_nxt;
  logic [1:0] meth_r;
  logic [1:0] meth_nxt;
  logic src_wr;
  logic meth_wr;
  assign src_wr = REG_WR && REG_ADDR == OFS_SRC_SEL;
  assign meth_wr = REG_WR && REG_ADDR == OFS_METHOD && !SERVO_EN;
  assign src_nxt = src_wr && REG_WDATA <= SRC_SEL_MAX ? REG_WDATA[2:0] : src_r;
  assign meth_nxt = meth_wr && REG_WDATA <= METHOD_MAX ? REG_WDATA[1:0]
                                                       : meth_r;
  always_ff @(posedge SYS_CLK) begin
    src_r <= SYS_RST ? SRC_MAIN : src_nxt;
    meth_r <= SYS_RST ? METH_SINGLE : meth_nxt;
  end

  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ==========================================================
  // Properties.
  a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data not zero outside the read cycle");
  a_run_start: assert property ($rose(SERVO_EN) ##1 SERVO_EN |-> ##1
    (SEQ_RUNNING)) else $error("sequencer did not start on enable");
  a_stop_holds: assert property (SEQ_STOPPED && SERVO_EN &&
    $past(SERVO_EN) |=> SEQ_STOPPED && $stable(ACTIVE_SEGMENT))
    else $error("stop not held");
  a_main_source: assert property ($past(src_r) == SRC_MAIN &&
    $past(!SYS_RST) |-> SPEED_CMD == $past(MAIN_SPEED))
    else $error("main source not passed");
  a_switch_source: assert property ($past(src_r) == SRC_SWITCH |->
    SPEED_CMD == ($past(MAIN_AUX_SWITCH) ? $past(AUX_SPEED)
                                         : $past(MAIN_SPEED)))
    else $error("switch source wrong");
  a_other_zero: assert property ($past(src_r) inside {3'h3, 3'h4, 3'h6,
    3'h7} |-> SPEED_CMD == 16'sh0000) else $error("unused source not zero");
  a_cycle_no_stop: assert property (meth_r == METH_CYCLE &&
    $past(meth_r) == METH_CYCLE && $past(meth_r, 2) == METH_CYCLE
    |-> !SEQ_STOPPED) else $error("cycle mode stopped");
  a_input_select: assert property (meth_r == METH_INPUT &&
    SEQ_RUNNING && $past(SEG_SELECT, 2) == SEG_SELECT &&
    $past(SEG_SELECT) == SEG_SELECT
    |-> ACTIVE_SEGMENT == SEG_SELECT) else $error("input segment wrong");

  c_stop: cover property (SEQ_STOPPED);
  c_cycle: cover property (meth_r == METH_CYCLE && ACTIVE_SEGMENT == 4'h0);
  c_input: cover property (meth_r == METH_INPUT && ACTIVE_SEGMENT == 4'hf);

endmodule

bind msseq_top msseq_assertions chk_u (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .SERVO_EN(SERVO_EN),
  .MAIN_AUX_SWITCH(MAIN_AUX_SWITCH), .SEG_SELECT(SEG_SELECT),
  .MAIN_SPEED(MAIN_SPEED), .AUX_SPEED(AUX_SPEED), .SPEED_CMD(SPEED_CMD),
  .ACTIVE_SEGMENT(ACTIVE_SEGMENT), .SEQ_RUNNING(SEQ_RUNNING),
  .SEQ_STOPPED(SEQ_STOPPED)
);

// ### verif/msseq_motor.sv
/*
  Downstream speed loop and motor, reduced to a slewing follower.
  Assumes the command is a registered signed rpm word.
*/
`timescale 1ns/100ps
module msseq_motor #(
  parameter int STEP = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [15:0] cmd,
  output logic signed [15:0] rpm
);
  // ==========================================================
  // Inertia.
  // The shaft slews a bounded step per clock and never jumps.
  logic signed [16:0] diff;
  logic signed [15:0] rpm_r;
  assign diff = 17'(cmd) - 17'(rpm_r);
  assign rpm = rpm_r;
  always_ff @(posedge clk) begin
    if (rst)
      rpm_r <= 16'sh0000;
    else if (diff > STEP)
      rpm_r <= rpm_r + 16'(STEP);
    else if (diff < -STEP)
      rpm_r <= rpm_r - 16'(STEP);
    else
      rpm_r <= cmd;
  end
endmodule

// ### verif/msseq_tb.sv
/*
  Self-checking bench of the multi-speed sequencer.
  Assumes msseq_top built with US_DIV of 1, so one ms is 1000 clocks.
*/
`timescale 1ns/100ps
module msseq_tb
  import msseq_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic en = 1'b0;
  logic sw = 1'b0;
  logic [3:0] sel = 4'h0;
  logic signed [15:0] main_spd = 16'sh0000;
  logic signed [15:0] aux_spd = 16'sh0000;
  logic [15:0] rdata;
  logic signed [15:0] cmd;
  logic signed [15:0] motor_rpm;
  logic [3:0] act;
  logic running;
  logic stopped;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int s;
  int n;
  int wraps;
  int halts;
  logic [3:0] prev;
  logic [15:0] spd[16];
  logic [7:0] ra[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0d,
                         8'h40, 8'h41, 8'h42, 8'h43, 8'h80};
  logic [15:0] rv[12] = '{16'h0000, 16'h0010, 16'h0001, 16'h01f4, 16'h01f4,
    16'h01f4, 16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0] ba[7] = '{8'h01, 8'h01, 8'h00, 8'h02, 8'h03, 8'h42, 8'h40};
  logic [15:0] bd[7] = '{16'h0000, 16'h0011, 16'h0003, 16'h0002, 16'h8000,
                         16'h0005, 16'h8000};
  logic [15:0] bx[7] = '{16'h0010, 16'h0010, 16'h0000, 16'h0001, 16'h01f4,
                         16'h0000, 16'h0000};

  msseq_top #(.US_DIV(1)) dut_u (
    .SYS_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .SERVO_EN(en),
    .MAIN_AUX_SWITCH(sw), .SEG_SELECT(sel), .MAIN_SPEED(main_spd),
    .AUX_SPEED(aux_spd), .SPEED_CMD(cmd), .ACTIVE_SEGMENT(act),
    .SEQ_RUNNING(running), .SEQ_STOPPED(stopped)
  );
  msseq_motor motor_u (.clk(clk), .rst(rst), .cmd(cmd), .rpm(motor_rpm));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Helpers.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] rnd_spd();
    return 16'($urandom_range(65534)) - 16'h7fff;
  endfunction

  function automatic logic [15:0] exp_cmd(int src, logic s1,
                                          logic [15:0] m, logic [15:0] a);
    if (src == 0 || (src == 2 && !s1))
      return m;
    if (src == 1 || src == 2)
      return a;
    return 16'h0000;
  endfunction

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================
  // Scenarios.
  initial begin
    void'($urandom(32'ha37e998f));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (s = 0; s < 12; s++) rd_reg(ra[s], rv[s]);
    for (s = 0; s < 7; s++) begin
      wr_reg(ba[s], bd[s]);
      rd_reg(ba[s], bx[s]);
    end
    n = $urandom_range(16, 1);
    wr_reg(OFS_TOTAL, 16'(n));
    rd_reg(OFS_TOTAL, 16'(n));
    for (s = 0; s < 8; s++) begin
      if (s != 5) begin
        wr_reg(OFS_SRC_SEL, 16'(s));
        for (n = 0; n < 3; n++) begin
          @(posedge clk);
          main_spd <= rnd_spd();
          aux_spd <= rnd_spd();
          sw <= n[0];
          cyc(2);
          chk(cmd, exp_cmd(s, sw, main_spd, aux_spd));
        end
      end
    end
    // Zero ramp times make the command jump, so speeds compare exactly.
    wr_reg(OFS_GEN_ACCEL, 16'h0000);
    wr_reg(OFS_GEN_DECEL, 16'h0000);
    wr_reg(OFS_SRC_SEL, 16'h0005);
    wr_reg(OFS_TOTAL, 16'h0002);
    wr_reg(8'h41, 16'h0000);
    wr_reg(8'h45, 16'h0000);
    wr_reg(8'h40, rnd_spd());
    en <= 1'b1;
    wr_reg(OFS_METHOD, 16'h0001);
    for (n = 0; n < 40 && stopped !== 1'b1; n++) cyc(1);
    chk(16'(stopped), 16'h0001);
    chk(16'(act), 16'h0001);
    cyc(3);
    chk(cmd, 16'h0000);
    rd_reg(OFS_METHOD, 16'h0000);
    @(posedge clk) en <= 1'b0;
    wr_reg(OFS_METHOD, 16'h0001);
    rd_reg(OFS_METHOD, 16'h0001);
    wr_reg(OFS_TOTAL, 16'h0003);
    wr_reg(8'h49, 16'h0000);
    en <= 1'b1;
    wraps = 0;
    halts = 0;
    prev = 4'h0;
    for (n = 0; n < 60; n++) begin
      cyc(1);
      if (prev === 4'h2 && act === 4'h0)
        wraps++;
      if (stopped !== 1'b0 || act > 4'h2)
        halts++;
      prev = act;
    end
    chk(16'(wraps > 1), 16'h0001);
    chk(16'(halts), 16'h0000);
    @(posedge clk) en <= 1'b0;
    wr_reg(OFS_METHOD, 16'h0002);
    for (s = 0; s < 16; s++) begin
      spd[s] = rnd_spd();
      wr_reg(8'(8'h40 + 4 * s), spd[s]);
    end
    en <= 1'b1;
    for (n = 0; n < 10; n++) begin
      @(posedge clk) sel <= n == 0 ? 4'h0 : (n == 1 ? 4'hf : 4'($urandom));
      cyc(6);
      chk(16'(act), 16'(sel));
      chk(cmd, spd[sel]);
      chk(16'(running), 16'h0001);
    end
    @(posedge clk) en <= 1'b0;
    wr_reg(OFS_METHOD, 16'h0000);
    wr_reg(OFS_TOTAL, 16'h0001);
    wr_reg(OFS_UNIT, 16'h0000);
    wr_reg(8'h41, 16'h0001);
    en <= 1'b1;
    for (n = 0; n < 3000 && stopped !== 1'b1; n++) cyc(1);
    chk(16'(n >= 1000 && n <= 1010), 16'h0001);
    cyc(1100);
    chk(motor_rpm, 16'h0000);
    complete_run();
  end
endmodule
